/* File: verification/mrc_cmd_status_chk.sv */
// Purpose: Port checks for the command interpreter and status byte
// Assumes: Mask copied here from the mask write strobe
// Notes: Bound to every instance of the block
`timescale 1ns/100ps
module mrc_chk
	import mrc_pkg::*;
(
	// Clock and reset
	input wire logic       clk_i,
	input wire logic       rst_i,
	// Inputs watched
	input wire logic       cmd_valid_i,
	input wire mrc_cmd_t   cmd_i,
	input wire logic       srq_mask_we_i,
	input wire logic [3:0] srq_mask_i,
	input wire logic       integ_busy_i,
	input wire logic       print_busy_i,
	input wire logic       comp_end_i,
	input wire logic       integ_end_i,
	input wire logic       overrange_i,
	input wire logic       cmd_error_i,
	input wire logic       poll_i,
	// Outputs watched
	input wire logic [7:0] poll_byte_o,
	input wire logic       srq_o,
	input wire logic [7:0] err_num_o,
	input wire logic       span_qry_valid_o,
	input wire mrc_panel_t panel_o,
	input wire logic       send_header_o
);
	logic [3:0] mask_q;
	logic [3:0] ev_w;
	assign ev_w = {overrange_i, cmd_error_i, integ_end_i, comp_end_i};
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) mask_q <= MRC_MASK_RESET;
		else if (srq_mask_we_i) mask_q <= srq_mask_i;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	busy_bit_a: assert property (poll_i |=> poll_byte_o[7] == $past(integ_busy_i))
		else $error("busy bit wrong");
	print_bit_a: assert property (poll_i |=> poll_byte_o[4] == $past(print_busy_i))
		else $error("print bit wrong");
	srq_set_a: assert property (|(ev_w & mask_q) |=> srq_o)
		else $error("srq not raised");
	srq_clear_a: assert property (poll_i && ev_w == 4'h0 && !cmd_valid_i |=> !srq_o)
		else $error("srq not cleared");
	srq_capt_a: assert property (poll_i |=> poll_byte_o[6] == $past(srq_o))
		else $error("srq bit wrong");
	cur_busy_a: assert property (cmd_valid_i && cmd_i.op == MRC_OP_CUR_SPAN && integ_busy_i
		|=> err_num_o == MRC_ERR_EXEC && $stable(panel_o.cur_span)) else $error("span taken");
	smp_busy_a: assert property (cmd_valid_i && cmd_i.op == MRC_OP_SAMPLE && integ_busy_i
		|=> err_num_o == MRC_ERR_EXEC && $stable(panel_o.sample)) else $error("period taken");
	qry_all_a: assert property (cmd_valid_i && cmd_i.op == MRC_OP_SPAN_QRY && cmd_i.elem == 2'h0
		|=> err_num_o == MRC_ERR_PARAM && !span_qry_valid_o) else $error("query answered");
	hdr_fmt_a: assert property (cmd_valid_i && cmd_i.op == MRC_OP_FORMAT && cmd_i.arg1 <= MRC_FMT_MAX
		|=> send_header_o == !$past(cmd_i.arg1[0])) else $error("header wrong");
endmodule : mrc_chk
bind mrc_cmd_status mrc_chk i_chk (.clk_i, .rst_i, .cmd_valid_i, .cmd_i, .srq_mask_we_i,
	.srq_mask_i, .integ_busy_i, .print_busy_i, .comp_end_i, .integ_end_i, .overrange_i,
	.cmd_error_i, .poll_i, .poll_byte_o, .srq_o, .err_num_o, .span_qry_valid_o, .panel_o,
	.send_header_o);

/* File: verification/mrc_cmd_status_tb.sv */
// Purpose: Self-checking bench for the command interpreter
// Assumes: Parsed commands, one-cycle events
// Notes: Gain apply and store commands are not exercised, a known gap
`timescale 1ns/100ps
module mrc_cmd_status_tb import mrc_pkg::*;;
	logic        clk_i = 1'b0, rst_i = 1'b1, cmd_valid_i = 1'b0, srq_mask_we_i = 1'b0;
	logic        four_wire_i = 1'b0, new_rom_i = 1'b1, integ_busy_i = 1'b0, harmonic_i = 1'b0;
	logic        print_busy_i = 1'b0, poll_tb = 1'b0, host_en = 1'b0, e6 = 1'b0;
	logic        host_poll, poll_i, srq_o, done_o, span_qry_valid_o, send_header_o, over_cause_o;
	logic [3:0]  srq_mask_i = 4'h0, evt = 4'h0, mask_m = MRC_MASK_RESET, sb = 4'h0, span_qry_o;
	logic [7:0]  poll_byte_o, err_num_o;
	logic [63:0] pv;
	logic [1:0]  rel;
	logic        zero_cal_o;
	logic [4:0]  clk_hour_o;
	logic [5:0]  clk_min_o, clk_sec_o;
	logic [MRC_ELEMS-1:0][15:0] gain_int_o, gain_frac_o;
	mrc_cmd_t    cmd_i = '0;
	mrc_panel_t  panel_o;
	int          fail_count = 0, cmp_count = 0, vs_m = 9, seed = 32'hDF18;
	mrc_op_t     bad_op [4] = '{MRC_OP_RATED_TIME, MRC_OP_RECALL, MRC_OP_CLOCK, MRC_OP_PRESET};
	logic [15:0] bad_arg [4] = '{16'h0000, 16'h0009, 16'h0018, 16'h03E8};
	assign poll_i = poll_tb | host_poll;
	mrc_cmd_status i_dut (.clk_i, .rst_i, .cmd_valid_i, .cmd_i, .srq_mask_we_i, .srq_mask_i,
		.four_wire_i, .new_rom_i, .integ_busy_i, .harmonic_i, .print_busy_i, .comp_end_i(evt[0]),
		.integ_end_i(evt[1]), .overrange_i(evt[3]), .cmd_error_i(evt[2]), .poll_i, .poll_byte_o,
		.srq_o, .done_o, .err_num_o, .over_cause_o, .span_qry_valid_o, .span_qry_o, .panel_o,
		.gain_int_o, .gain_frac_o, .zero_cal_o, .clk_hour_o, .clk_min_o,
		.clk_sec_o, .send_header_o);
	mrc_host i_host (.clk_i, .en_i(host_en), .srq_i(srq_o), .poll_o(host_poll));
	always #50 clk_i = ~clk_i;
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task automatic cmd(input mrc_op_t op, input logic [1:0] el, input logic [15:0] a1,
		input logic [15:0] a2 = 16'h0000, input logic [15:0] a3 = 16'h0000);
		@(posedge clk_i);
		cmd_valid_i <= 1'b1;
		cmd_i <= '{op: op, elem: el, arg1: a1, arg2: a2, arg3: a3};
		@(posedge clk_i);
		cmd_valid_i <= 1'b0;
		#1 chk("done", done_o, 1'b1);
	endtask : cmd
	task automatic ev(input int k);
		@(posedge clk_i);
		evt[k] <= 1'b1;
		@(posedge clk_i);
		evt <= 4'h0;
		sb[k] = sb[k] | mask_m[k];
		e6 = e6 | (k > 1);
		#1 chk("srq", srq_o, |sb);
	endtask : ev
	task automatic poll(input bit ck);
		@(posedge clk_i);
		poll_tb <= 1'b1;
		@(posedge clk_i);
		poll_tb <= 1'b0;
		#1 if (ck) chk("status", poll_byte_o, {integ_busy_i, |sb, e6, print_busy_i, sb});
		sb = 4'h0;
		e6 = 1'b0;
		chk("srq", srq_o, 1'b0);
	endtask : poll
	task automatic setm(input logic [3:0] m);
		@(posedge clk_i);
		srq_mask_we_i <= 1'b1;
		srq_mask_i <= m;
		@(posedge clk_i);
		srq_mask_we_i <= 1'b0;
		mask_m = m;
	endtask : setm
	task final_report;
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	initial begin
		#2000000;
		fail_count++;
		final_report();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		#1 chk("panel", panel_o, MRC_PANEL_DEFAULT);
		chk("header", send_header_o, 1'b1);
		for (int c = 2; c < 12; c++) begin
			rel = 2'($random(seed));
			cmd(MRC_OP_VOLT_SPAN, rel, 16'(c));
			// Element 2 is refused while the four-wire strap is low
			if (c >= 3 && c <= 10 && rel != 2'h2) vs_m = c;
			else chk("err", err_num_o, 8'h0C);
			chk("vspan", panel_o.volt_span, vs_m);
		end
		cmd(MRC_OP_SPAN_QRY, 2'h1, 16'h0000);
		chk("query", {span_qry_valid_o, span_qry_o}, {1'b1, 4'(vs_m)});
		cmd(MRC_OP_SPAN_QRY, 2'h0, 16'h0000);
		chk("err", err_num_o, 8'h0C);
		$display("test span done");
		for (int c = 0; c < 6; c++) begin
			cmd(MRC_OP_SAMPLE, 2'h0, 16'(c));
			chk("sample", panel_o.sample, (c < 5) ? c : 4);
		end
		integ_busy_i <= 1'b1;
		cmd(MRC_OP_SAMPLE, 2'h0, 16'h0001);
		chk("sample", panel_o.sample, 3'h4);
		cmd(MRC_OP_CUR_SPAN, 2'h1, 16'h0005);
		chk("cspan", {err_num_o, panel_o.cur_span}, {8'h0D, 5'h09});
		cmd(MRC_OP_ZERO_CAL, 2'h0, 16'h0000);
		chk("err", err_num_o, 8'h0D);
		integ_busy_i <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			pv = panel_o;
			cmd(bad_op[i], 2'h0, bad_arg[i]);
			chk("refused", {err_num_o, panel_o}, {8'h0C, pv[48:0]});
		end
		cmd(MRC_OP_WIRING, 2'h0, 16'h0004);
		chk("err", err_num_o, 8'h0C);
		four_wire_i <= 1'b1;
		cmd(MRC_OP_WIRING, 2'h0, 16'h0005);
		cmd(MRC_OP_FORMAT, 2'h0, 16'h0001);
		chk("fmt", {panel_o.wiring, send_header_o}, 4'hA);
		cmd(MRC_OP_PANEL_INIT, 2'h0, 16'h0000);
		chk("panel", panel_o, MRC_PANEL_DEFAULT);
		$display("test settings done");
		poll(1'b0);
		for (int j = 0; j < 6; j++) begin
			setm(j == 0 ? 4'hF : 4'(1 << (j - 1)) & {4{j < 5}});
			for (int k = 0; k < 4; k++) ev(k);
			if (mask_m[3]) chk("cause", over_cause_o, 1'b1);
			print_busy_i <= 1'($random(seed));
			integ_busy_i <= 1'($random(seed));
			poll(1'b1);
		end
		$display("test status done");
		integ_busy_i <= 1'b0;
		cmd(MRC_OP_SENSOR_GAIN, 2'h0, 16'h0000, 16'h03E8);
		chk("gain", {gain_int_o[2], gain_frac_o[2]}, {16'h0000, 16'h03E8});
		new_rom_i <= 1'b0;
		cmd(MRC_OP_SENSOR_GAIN, 2'h1, 16'h0000, 16'h1388);
		chk("gain", {err_num_o, gain_frac_o[0]}, {8'h0C, 16'h03E8});
		cmd(MRC_OP_SENSOR_GAIN, 2'h1, 16'h2710, 16'h0000);
		chk("gain", {gain_int_o[0], gain_frac_o[0]}, {16'h2710, 16'h0000});
		cmd(MRC_OP_CLOCK, 2'h0, 16'h0017, 16'h003B, 16'h003B);
		chk("clock", {clk_hour_o, clk_min_o, clk_sec_o}, {5'h17, 6'h3B, 6'h3B});
		cmd(MRC_OP_ZERO_CAL, 2'h0, 16'h0000);
		chk("zero", zero_cal_o, 1'b1);
		harmonic_i <= 1'b1;
		cmd(MRC_OP_ZERO_CAL, 2'h0, 16'h0000);
		chk("zero", zero_cal_o, 1'b0);
		harmonic_i <= 1'b0;
		$display("test gain clock done");
		setm(4'hF);
		host_en <= 1'b1;
		ev(0);
		repeat (20) if (srq_o) @(posedge clk_i);
		#1 chk("srq", srq_o, 1'b0);
		sb = 4'h0;
		host_en <= 1'b0;
		$display("test host done");
		final_report();
	end
endmodule : mrc_cmd_status_tb

/* File: verification/mrc_host.sv */
// Purpose: Remote controller answering a service request with a serial poll
// Assumes: Poll strobe lasts one cycle
// Notes: DLY keeps it slow, as a real controller is
`timescale 1ns/100ps
module mrc_host #(
	parameter int DLY = 3
) (
	// Clock and control
	input  wire logic clk_i,
	input  wire logic en_i,
	// Request in, poll out
	input  wire logic srq_i,
	output logic      poll_o
);
	int cnt = 0;
	initial poll_o = 1'b0;
	always @(posedge clk_i) begin
		poll_o <= (cnt == DLY);
		cnt <= (en_i && srq_i && !poll_o) ? cnt + 1 : 0;
	end
endmodule : mrc_host

/* File: verilog/mrc_cmd_status.sv */
// Purpose: Remote command interpreter and status byte of a power meter
// Assumes: One command per cmd_valid_i pulse; events are one-cycle pulses
// Notes: Communication settings live outside and are never touched here
`timescale 1ns/100ps
module mrc_cmd_status
	import mrc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Parsed command
	input  wire logic       cmd_valid_i,
	input  wire mrc_cmd_t   cmd_i,
	input  wire logic       srq_mask_we_i,
	input  wire logic [3:0] srq_mask_i,
	// Variant straps
	input  wire logic       four_wire_i,
	input  wire logic       new_rom_i,
	// Measurement events and state
	input  wire logic       integ_busy_i,
	input  wire logic       harmonic_i,
	input  wire logic       print_busy_i,
	input  wire logic       comp_end_i,
	input  wire logic       integ_end_i,
	input  wire logic       overrange_i,
	input  wire logic       cmd_error_i,
	// Serial poll
	input  wire logic       poll_i,
	output logic      [7:0] poll_byte_o,
	output logic            srq_o,
	// Results
	output logic            done_o,
	output logic      [7:0] err_num_o,
	output logic            over_cause_o,
	output logic            span_qry_valid_o,
	output logic      [3:0] span_qry_o,
	output mrc_panel_t      panel_o,
	output logic [MRC_ELEMS-1:0][15:0] gain_int_o,
	output logic [MRC_ELEMS-1:0][15:0] gain_frac_o,
	output logic            zero_cal_o,
	output logic      [4:0] clk_hour_o,
	output logic      [5:0] clk_min_o,
	output logic      [5:0] clk_sec_o,
	output logic            send_header_o
);
	mrc_panel_t  panel_q, panel_d;
	mrc_panel_t  files_q [MRC_FILES];
	logic [MRC_ELEMS-1:0][15:0] gint_q, gfrac_q;
	logic [3:0]  mask_q;
	logic [5:0]  sb_q;
	logic [7:0]  err_q, poll_q;
	logic        over_q, done_q, qv_q, zc_q;
	logic [3:0]  qspan_q;
	logic [4:0]  hh_q;
	logic [5:0]  mm_q, ss_q;

	wire logic       go        = cmd_valid_i;
	wire mrc_op_t    op        = cmd_i.op;
	wire logic [15:0] a1       = cmd_i.arg1;
	wire logic [15:0] a2       = cmd_i.arg2;
	wire logic [15:0] a3       = cmd_i.arg3;
	wire logic       elem_ok   = (cmd_i.elem != 2'h2) || four_wire_i;
	wire logic       hm_ok     = (a1 <= MRC_HOUR_MAX) && (a2 <= MRC_MIN_MAX);
	wire logic       rated_ok  = hm_ok && ((a1 != 16'h0000) || (a2 != 16'h0000));
	wire logic       vspan_ok  = (a1[15:4] == 12'h000) && (a1[3:0] >= MRC_VSPAN_MIN)
		&& (a1[3:0] <= MRC_VSPAN_MAX);
	wire logic       cspan_ok  = (a1[15:5] == 11'h000) && (a1[4:0] >= MRC_CSPAN_MIN)
		&& (a1[4:0] <= MRC_CSPAN_MAX);
	wire logic [15:0] gmin     = new_rom_i ? MRC_GAIN_NEW_MIN : MRC_GAIN_OLD_MIN;
	// Gain as integer.fraction; low limit compared on integer*1e4-scaled fraction
	wire logic [31:0] gval     = 32'(a1) * 32'd10000 + 32'(a2);
	// Limit constants are already in 1e-4 units, so no rescale is needed
	wire logic [31:0] glo      = 32'(gmin);
	wire logic       gain_ok   = (a2 <= MRC_FRAC_MAX) && (gval >= glo)
		&& ((a1 < MRC_GAIN_INT_MAX) || ((a1 == MRC_GAIN_INT_MAX) && (a2 == 16'h0000)));
	wire logic       file_ok   = (a1 >= MRC_FILE_MIN) && (a1 <= MRC_FILE_MAX);
	wire logic [2:0] fidx      = 3'(a1 - MRC_FILE_MIN);
	wire logic       clock_ok  = (a1 <= MRC_DAYH_MAX) && (a2 <= MRC_MIN_MAX)
		&& (a3 <= MRC_MIN_MAX);
	wire logic [15:0] wmax     = four_wire_i ? MRC_WIRE_MAX4 : MRC_WIRE_MAX3;
	wire logic       wire_ok   = (a1 != 16'h0000) && (a1 <= wmax);
	wire logic       busy_op   = (op == MRC_OP_CUR_SPAN) || (op == MRC_OP_VOLT_SPAN)
		|| (op == MRC_OP_SAMPLE) || (op == MRC_OP_ZERO_CAL);
	wire logic       exec_err  = busy_op && integ_busy_i;
	logic       par_ok;
	logic [7:0] err_d;

	always_comb begin
		par_ok = 1'b1;
		case (op)
			MRC_OP_CUR_SPAN:    par_ok = cspan_ok && elem_ok;
			MRC_OP_VOLT_SPAN:   par_ok = vspan_ok && elem_ok;
			MRC_OP_SPAN_QRY:    par_ok = (cmd_i.elem != 2'h0) && elem_ok;
			MRC_OP_RATED_TIME:  par_ok = rated_ok;
			MRC_OP_SENSOR_GAIN: par_ok = gain_ok && elem_ok;
			MRC_OP_GAIN_APPLY:  par_ok = a1 <= MRC_FMT_MAX;
			MRC_OP_SAMPLE:      par_ok = a1 <= MRC_SAMPLE_MAX;
			MRC_OP_STORE:       par_ok = file_ok;
			MRC_OP_RECALL:      par_ok = file_ok;
			MRC_OP_CLOCK:       par_ok = clock_ok;
			MRC_OP_PRESET:      par_ok = hm_ok;
			MRC_OP_FORMAT:      par_ok = a1 <= MRC_FMT_MAX;
			MRC_OP_WIRING:      par_ok = wire_ok;
			default:            par_ok = 1'b1;
		endcase
		if (!par_ok)
			err_d = MRC_ERR_PARAM;
		else if (exec_err)
			err_d = MRC_ERR_EXEC;
		else
			err_d = MRC_ERR_NONE;
	end

	wire logic accept = go && (err_d == MRC_ERR_NONE);

	always_comb begin
		panel_d = panel_q;
		if (accept) begin
			case (op)
				MRC_OP_CUR_SPAN:   panel_d.cur_span = a1[4:0];
				MRC_OP_VOLT_SPAN:  panel_d.volt_span = a1[3:0];
				MRC_OP_PANEL_INIT: panel_d = MRC_PANEL_DEFAULT;
				MRC_OP_RATED_TIME: begin
					panel_d.rated_h = a1[9:0];
					panel_d.rated_m = a2[5:0];
				end
				MRC_OP_GAIN_APPLY: panel_d.gain_on = a1[0];
				MRC_OP_SAMPLE:     panel_d.sample = a1[2:0];
				MRC_OP_RECALL:     panel_d = files_q[fidx];
				MRC_OP_PRESET: begin
					panel_d.preset_h = a1[9:0];
					panel_d.preset_m = a2[5:0];
				end
				MRC_OP_FORMAT:     panel_d.binary_fmt = a1[0];
				MRC_OP_WIRING:     panel_d.wiring = a1[2:0];
				default:           panel_d = panel_q;
			endcase
		end
	end

	// Enabled events; busy bits never reach the request
	wire logic [3:0] ev     = {overrange_i, cmd_error_i || (go && err_d != MRC_ERR_NONE),
		integ_end_i, comp_end_i};
	wire logic [3:0] ev_en  = ev & mask_q;
	wire logic [5:0] ev_set = {overrange_i || ev[2], ev_en[3], ev_en[2], ev_en[1],
		ev_en[0], 1'b0} >> 1;
	wire logic [4:0] sticky = sb_q[4:0];
	wire logic       srq    = |sb_q[3:0];
	wire logic [7:0] live   = {integ_busy_i, srq, sb_q[4], print_busy_i, sb_q[3:0]};

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			panel_q <= MRC_PANEL_DEFAULT;
			mask_q  <= MRC_MASK_RESET;
			sb_q    <= 6'h00;
			err_q   <= MRC_ERR_NONE;
			poll_q  <= 8'h00;
			over_q  <= 1'b0;
		end else begin
			panel_q <= panel_d;
			if (srq_mask_we_i)
				mask_q <= srq_mask_i;
			// Poll snapshot and clear in one edge; events this edge survive
			if (poll_i)
				poll_q <= live;
			sb_q <= {1'b0, (poll_i ? 5'h00 : sticky) | ev_set[4:0]};
			if (go && err_d != MRC_ERR_NONE)
				err_q <= err_d;
			if (overrange_i)
				over_q <= 1'b1;
			else if (poll_i)
				over_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			done_q  <= 1'b0;
			qv_q    <= 1'b0;
			qspan_q <= 4'h0;
			zc_q    <= 1'b0;
			hh_q    <= 5'h00;
			mm_q    <= 6'h00;
			ss_q    <= 6'h00;
			gint_q  <= '0;
			gfrac_q <= '0;
		end else begin
			done_q  <= go;
			qv_q    <= accept && (op == MRC_OP_SPAN_QRY);
			qspan_q <= panel_q.volt_span;
			zc_q    <= accept && (op == MRC_OP_ZERO_CAL) && !harmonic_i;
			if (accept && op == MRC_OP_CLOCK) begin
				hh_q <= a1[4:0];
				mm_q <= a2[5:0];
				ss_q <= a3[5:0];
			end
			for (int e = 0; e < MRC_ELEMS; e++) begin
				if (accept && op == MRC_OP_SENSOR_GAIN
						&& (cmd_i.elem == 2'h0 || cmd_i.elem == 2'(e + 1))) begin
					gint_q[e]  <= a1;
					gfrac_q[e] <= a2;
				end
			end
		end
	end

	// Setup files are storage only; recall above keeps comms since they live outside
	always_ff @(posedge clk_i) begin
		if (accept && op == MRC_OP_STORE)
			files_q[fidx] <= panel_q;
	end

	assign poll_byte_o      = poll_q;
	assign srq_o            = srq;
	assign done_o           = done_q;
	assign err_num_o        = err_q;
	assign over_cause_o     = over_q;
	assign span_qry_valid_o = qv_q;
	assign span_qry_o       = qspan_q;
	assign panel_o          = panel_q;
	assign gain_int_o       = gint_q;
	assign gain_frac_o      = gfrac_q;
	assign zero_cal_o       = zc_q;
	assign clk_hour_o       = hh_q;
	assign clk_min_o        = mm_q;
	assign clk_sec_o        = ss_q;
	assign send_header_o    = !panel_q.binary_fmt;
endmodule : mrc_cmd_status

/* File: verilog/mrc_pkg.sv */
// Purpose: Constants and types for the meter remote command interpreter
// Assumes: Commands arrive already parsed into opcode and numeric arguments
package mrc_pkg;
	typedef enum logic [3:0] {
		MRC_OP_NONE, MRC_OP_CUR_SPAN, MRC_OP_VOLT_SPAN, MRC_OP_SPAN_QRY, MRC_OP_PANEL_INIT,
		MRC_OP_RATED_TIME, MRC_OP_SENSOR_GAIN, MRC_OP_GAIN_APPLY, MRC_OP_SAMPLE,
		MRC_OP_STORE, MRC_OP_RECALL, MRC_OP_CLOCK, MRC_OP_PRESET, MRC_OP_FORMAT,
		MRC_OP_WIRING, MRC_OP_ZERO_CAL
	} mrc_op_t;

	typedef struct packed {
		mrc_op_t     op;
		logic [1:0]  elem;
		logic [15:0] arg1;
		logic [15:0] arg2;
		logic [15:0] arg3;
	} mrc_cmd_t;

	typedef struct packed {
		logic [4:0] cur_span;
		logic [3:0] volt_span;
		logic [2:0] sample;
		logic       gain_on;
		logic       binary_fmt;
		logic [2:0] wiring;
		logic [9:0] rated_h;
		logic [5:0] rated_m;
		logic [9:0] preset_h;
		logic [5:0] preset_m;
	} mrc_panel_t;

	localparam logic [7:0] MRC_ERR_NONE  = 8'h00;
	localparam logic [7:0] MRC_ERR_PARAM = 8'h0C;
	localparam logic [7:0] MRC_ERR_EXEC  = 8'h0D;

	localparam logic [3:0]  MRC_VSPAN_MIN  = 4'h3;
	localparam logic [3:0]  MRC_VSPAN_MAX  = 4'hA;
	localparam logic [4:0]  MRC_CSPAN_MIN  = 5'h04;
	localparam logic [4:0]  MRC_CSPAN_MAX  = 5'h17;
	localparam logic [15:0] MRC_HOUR_MAX   = 16'h03E7;
	localparam logic [15:0] MRC_MIN_MAX    = 16'h003B;
	localparam logic [15:0] MRC_DAYH_MAX   = 16'h0017;
	localparam logic [15:0] MRC_SAMPLE_MAX = 16'h0004;
	localparam logic [15:0] MRC_FILE_MIN   = 16'h0001;
	localparam logic [15:0] MRC_FILE_MAX   = 16'h0008;
	localparam logic [15:0] MRC_WIRE_MAX3  = 16'h0003;
	localparam logic [15:0] MRC_WIRE_MAX4  = 16'h0005;
	localparam logic [15:0] MRC_FMT_MAX    = 16'h0001;
	// Gain held in units of 1e-4 above the integer part: arg1 integer, arg2 fraction
	localparam logic [15:0] MRC_GAIN_INT_MAX = 16'h2710;
	localparam logic [15:0] MRC_GAIN_NEW_MIN = 16'h03E8;
	localparam logic [15:0] MRC_GAIN_OLD_MIN = 16'h2328;
	localparam logic [15:0] MRC_FRAC_MAX     = 16'h270F;

	localparam int MRC_FILES = 8;
	localparam int MRC_ELEMS = 3;

	localparam int MRC_SB_COMP  = 0;
	localparam int MRC_SB_INTEG = 1;
	localparam int MRC_SB_SYNT  = 2;
	localparam int MRC_SB_OVER  = 3;
	localparam int MRC_SB_PRINT = 4;
	localparam int MRC_SB_ERROR = 5;
	localparam int MRC_SB_SRQ   = 6;
	localparam int MRC_SB_BUSY  = 7;

	localparam logic [3:0] MRC_MASK_RESET = 4'h0;

	localparam mrc_panel_t MRC_PANEL_DEFAULT = '{
		cur_span: 5'h09, volt_span: 4'h9, sample: 3'h0, gain_on: 1'b0,
		binary_fmt: 1'b0, wiring: 3'h1, rated_h: 10'h001, rated_m: 6'h00,
		preset_h: 10'h001, preset_m: 6'h00};
endpackage : mrc_pkg
